// File: design/dmx_defs.svh
`ifndef DMX_DEFS_SVH
`define DMX_DEFS_SVH

// ==================================================
// Register map (byte addresses)
`define DMX_ADDR_CTRL    12'h000
`define DMX_ADDR_STAT    12'h004
`define DMX_ADDR_COUNT   12'h008
`define DMX_CTRL_RST     1'b1
`define DMX_CTRL_EXEC    0
`define DMX_STAT_ACC_LO  0
`define DMX_STAT_BSR_LO  8
`define DMX_STAT_N       16
`define DMX_STAT_Z       17
`define DMX_STAT_EXT     18
`define DMX_STAT_BADDST  19
`define DMX_STAT_BUSY    20

// ==================================================
// Opcodes
`define DMX_OPC_COPY     6'b010100
`define DMX_OPC_MV_SRC   4'hc
`define DMX_OPC_MV_DST   4'hf
`define DMX_OPC_LOADB    8'h01
`define DMX_OPC_LOADA    8'h0e
`define DMX_OPC_STORE    7'b0110111

// ==================================================
// Data space
`define DMX_IDX_MAX      8'h5f
`define DMX_ACC_SPLIT    8'h60
`define DMX_ACC_HI_PAGE  4'hf
`define DMX_ACC_ADDR     12'hfe8
`define DMX_PCL_ADDR     12'hff9
`define DMX_RETURN_STACK_LOW_ADDR    12'hffd
`define DMX_RETURN_STACK_HIGH_ADDR    12'hffe
`define DMX_RETURN_STACK_UPPER_ADDR    12'hfff

`endif

// File: design/dmx_pkg.sv
package dmx_pkg;

  typedef enum logic [2:0] {
    DMX_ST_IDLE  = 3'b000,
    DMX_ST_Q1    = 3'b001,
    DMX_ST_Q2    = 3'b010,
    DMX_ST_Q3    = 3'b011,
    DMX_ST_Q4    = 3'b100,
    DMX_ST_WAIT2 = 3'b101
  } dmx_state_t;

  typedef enum logic [2:0] {
    DMX_OP_NONE  = 3'b000,
    DMX_OP_COPY  = 3'b001,
    DMX_OP_MOVE  = 3'b010,
    DMX_OP_LOADB = 3'b011,
    DMX_OP_LOADA = 3'b100,
    DMX_OP_STORE = 3'b101
  } dmx_op_t;

endpackage

// File: design/dmx_core.sv
`timescale 1ns/1ps
`include "dmx_defs.svh"

module dmx_core (
  input  wire logic               sys_clk,
  input  wire logic               sys_rst,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               ext_set_en,
  input  wire logic               instr_valid,
  input  wire logic [15:0]        instr_word,
  output logic                    instr_ready,
  output logic                    other_op,
  output logic [11:0]             mem_addr,
  output logic                    mem_rd,
  input  wire logic [7:0]         mem_rdata,
  output logic                    mem_wr,
  output logic [7:0]              mem_wdata,
  output logic                    idx_mode,
  output logic [7:0]              acc_value,
  output logic [7:0]              bsr_value,
  output logic                    flag_n,
  output logic                    flag_z,
  output dmx_pkg::dmx_state_t     phase
);
  import dmx_pkg::*;
  // ==================================================
  // State
  dmx_state_t  state_reg;
  dmx_op_t     op_dec;
  logic [15:0] word1_reg;
  logic [15:0] word2_reg;
  logic        second_reg;
  logic        ready_reg;
  logic        other_reg;
  logic        ext_meta_reg;
  logic        ext_reg;
  logic        exec_en_reg;
  logic        bad_dst_reg;
  logic [15:0] count_reg;
  logic [7:0]  acc_reg;
  logic [7:0]  bsr_reg;
  logic        n_reg;
  logic        z_reg;
  logic [7:0]  data_reg;
  logic        from_acc_reg;
  logic [11:0] maddr_reg;
  logic        mrd_reg;
  logic        mwr_reg;
  logic [7:0]  mwdata_reg;
  logic        idx_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;

  // ==================================================
  // Decode
  logic        dest_bit;
  logic        bank_bit;
  logic [7:0]  f_field;
  logic [7:0]  lit;
  logic        byte_idx;
  logic [11:0] byte_addr;
  logic [11:0] src_addr;
  logic [11:0] dst_addr;
  logic        dst_forbidden;
  logic        needs_read;
  logic [11:0] rd_addr;
  logic        rd_is_acc;
  logic        needs_wr;
  logic [11:0] wr_addr;
  logic        wr_is_acc;
  logic        bus_access;
  logic        bus_done;

  always_comb begin
    op_dec = DMX_OP_NONE;
    if (word1_reg[15:10] == `DMX_OPC_COPY) begin
      op_dec = DMX_OP_COPY;
    end else if (word1_reg[15:12] == `DMX_OPC_MV_SRC) begin
      op_dec = DMX_OP_MOVE;
    end else if (word1_reg[15:8] == `DMX_OPC_LOADB) begin
      op_dec = DMX_OP_LOADB;
    end else if (word1_reg[15:8] == `DMX_OPC_LOADA) begin
      op_dec = DMX_OP_LOADA;
    end else if (word1_reg[15:9] == `DMX_OPC_STORE) begin
      op_dec = DMX_OP_STORE;
    end
  end

  assign dest_bit = word1_reg[9];
  assign bank_bit = word1_reg[8];
  assign f_field  = word1_reg[7:0];
  assign lit      = word1_reg[7:0];
  // Indexed mode only flags the operand; the offset math lives elsewhere
  assign byte_idx = ext_reg && !bank_bit && (f_field <= `DMX_IDX_MAX);
  // Full 8-bit f reaches every byte of the chosen bank
  always_comb begin
    if (bank_bit) begin
      byte_addr = {bsr_reg[3:0], f_field};
    end else if (f_field < `DMX_ACC_SPLIT) begin
      byte_addr = {4'h0, f_field};
    end else begin
      byte_addr = {`DMX_ACC_HI_PAGE, f_field};
    end
  end
  assign src_addr = word1_reg[11:0];
  assign dst_addr = word2_reg[11:0];
  // Guard against code that breaks the destination restriction
  assign dst_forbidden = (dst_addr == `DMX_PCL_ADDR) || (dst_addr == `DMX_RETURN_STACK_LOW_ADDR) ||
                         (dst_addr == `DMX_RETURN_STACK_HIGH_ADDR) || (dst_addr == `DMX_RETURN_STACK_UPPER_ADDR);
  always_comb begin
    needs_read = 1'b0;
    rd_addr    = byte_addr;
    rd_is_acc  = 1'b0;
    if (op_dec == DMX_OP_COPY) begin
      needs_read = 1'b1;
      rd_is_acc  = !byte_idx && (byte_addr == `DMX_ACC_ADDR);
    end else if (op_dec == DMX_OP_MOVE && !second_reg) begin
      needs_read = 1'b1;
      rd_addr    = src_addr;
      rd_is_acc  = (src_addr == `DMX_ACC_ADDR);
    end
  end
  always_comb begin
    needs_wr  = 1'b0;
    wr_addr   = byte_addr;
    wr_is_acc = 1'b0;
    if (op_dec == DMX_OP_COPY) begin
      needs_wr  = dest_bit;
      wr_is_acc = !dest_bit || (!byte_idx && (byte_addr == `DMX_ACC_ADDR));
    end else if (op_dec == DMX_OP_STORE) begin
      needs_wr  = 1'b1;
      wr_is_acc = !byte_idx && (byte_addr == `DMX_ACC_ADDR);
    end else if (op_dec == DMX_OP_MOVE && second_reg) begin
      needs_wr  = !dst_forbidden;
      wr_addr   = dst_addr;
      wr_is_acc = (dst_addr == `DMX_ACC_ADDR);
    end
  end

  // ==================================================
  // Pin synchroniser for the static extended-set enable
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_meta_reg <= 1'b0;
      ext_reg      <= 1'b0;
    end else begin
      ext_meta_reg <= ext_set_en;
      ext_reg      <= ext_meta_reg;
    end
  end

  // ==================================================
  // Four-phase sequencer
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg  <= DMX_ST_IDLE;
      word1_reg  <= 16'h0000;
      word2_reg  <= 16'h0000;
      second_reg <= 1'b0;
      ready_reg  <= 1'b0;
      other_reg  <= 1'b0;
    end else begin
      other_reg <= 1'b0;
      case (state_reg)
        DMX_ST_IDLE: begin
          if (instr_valid && ready_reg) begin
            word1_reg  <= instr_word;
            second_reg <= 1'b0;
            ready_reg  <= 1'b0;
            state_reg  <= DMX_ST_Q1;
          end else begin
            ready_reg <= exec_en_reg;
          end
        end
        DMX_ST_Q1: begin
          if (op_dec == DMX_OP_NONE) begin
            other_reg <= 1'b1;
            state_reg <= DMX_ST_IDLE;
          end else begin
            state_reg <= DMX_ST_Q2;
          end
        end
        DMX_ST_Q2: state_reg <= DMX_ST_Q3;
        DMX_ST_Q3: state_reg <= DMX_ST_Q4;
        DMX_ST_Q4: begin
          if (op_dec == DMX_OP_MOVE && !second_reg) begin
            ready_reg <= 1'b1;
            state_reg <= DMX_ST_WAIT2;
          end else begin
            second_reg <= 1'b0;
            state_reg  <= DMX_ST_IDLE;
          end
        end
        DMX_ST_WAIT2: begin
          // A second word never starts a new instruction
          if (instr_valid && ready_reg) begin
            ready_reg <= 1'b0;
            if (instr_word[15:12] == `DMX_OPC_MV_DST) begin
              word2_reg  <= instr_word;
              second_reg <= 1'b1;
              state_reg  <= DMX_ST_Q1;
            end else begin
              other_reg <= 1'b1;
              state_reg <= DMX_ST_IDLE;
            end
          end
        end
        default: state_reg <= DMX_ST_IDLE;
      endcase
    end
  end

  // ==================================================
  // Data memory port
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      maddr_reg    <= 12'h000;
      mrd_reg      <= 1'b0;
      mwr_reg      <= 1'b0;
      mwdata_reg   <= 8'h00;
      idx_reg      <= 1'b0;
      from_acc_reg <= 1'b0;
      data_reg     <= 8'h00;
    end else begin
      mrd_reg <= 1'b0;
      mwr_reg <= 1'b0;
      if (state_reg == DMX_ST_Q1 && needs_read) begin
        from_acc_reg <= rd_is_acc;
        if (!rd_is_acc) begin
          maddr_reg <= rd_addr;
          mrd_reg   <= 1'b1;
          idx_reg   <= byte_idx && (op_dec == DMX_OP_COPY);
        end
      end
      if (state_reg == DMX_ST_Q3 && needs_read) begin
        data_reg <= from_acc_reg ? acc_reg : mem_rdata;
      end
      if (state_reg == DMX_ST_Q3 && needs_wr && !wr_is_acc) begin
        maddr_reg <= wr_addr;
        mwr_reg   <= 1'b1;
        idx_reg   <= byte_idx && (op_dec != DMX_OP_MOVE);
        if (op_dec == DMX_OP_STORE) begin
          mwdata_reg <= acc_reg;
        end else if (op_dec == DMX_OP_COPY) begin
          mwdata_reg <= from_acc_reg ? acc_reg : mem_rdata;
        end else begin
          mwdata_reg <= data_reg;
        end
      end
    end
  end

  // ==================================================
  // Accumulator, bank select and flags, all committed in the last phase
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_reg <= 8'h00;
      bsr_reg <= 8'h00;
      n_reg   <= 1'b0;
      z_reg   <= 1'b0;
    end else if (state_reg == DMX_ST_Q4) begin
      case (op_dec)
        DMX_OP_COPY: begin
          if (wr_is_acc) begin
            acc_reg <= data_reg;
          end
          n_reg <= data_reg[7];
          z_reg <= (data_reg == 8'h00);
        end
        DMX_OP_MOVE: begin
          if (second_reg && wr_is_acc) begin
            acc_reg <= data_reg;
          end
        end
        DMX_OP_LOADB: begin
          bsr_reg <= {4'h0, lit[3:0]};
        end
        DMX_OP_LOADA: begin
          acc_reg <= lit;
        end
        default: ;
      endcase
    end
  end
  // Completed instructions; a two-word copy counts once
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_reg <= 16'h0000;
    end else if (state_reg == DMX_ST_Q4 && !(op_dec == DMX_OP_MOVE && !second_reg)) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  // ==================================================
  // APB slave: pready one cycle into the access phase
  assign bus_access = psel && penable;
  assign bus_done   = bus_access && pready_reg;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      if (bus_access && !pready_reg) begin
        pready_reg <= 1'b1;
        prdata_reg <= 32'h0000_0000;
        if (paddr == `DMX_ADDR_CTRL) begin
          prdata_reg[`DMX_CTRL_EXEC] <= exec_en_reg;
        end else if (paddr == `DMX_ADDR_STAT) begin
          prdata_reg[`DMX_STAT_ACC_LO +: 8] <= acc_reg;
          prdata_reg[`DMX_STAT_BSR_LO +: 4] <= bsr_reg[3:0];
          prdata_reg[`DMX_STAT_N]      <= n_reg;
          prdata_reg[`DMX_STAT_Z]      <= z_reg;
          prdata_reg[`DMX_STAT_EXT]    <= ext_reg;
          prdata_reg[`DMX_STAT_BADDST] <= bad_dst_reg;
          prdata_reg[`DMX_STAT_BUSY]   <= (state_reg != DMX_ST_IDLE);
        end else if (paddr == `DMX_ADDR_COUNT) begin
          prdata_reg[15:0] <= count_reg;
        end else begin
          pslverr_reg <= 1'b1;
        end
      end
    end
  end
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      exec_en_reg <= `DMX_CTRL_RST;
    end else if (bus_done && pwrite && paddr == `DMX_ADDR_CTRL) begin
      exec_en_reg <= pwdata[`DMX_CTRL_EXEC];
    end
  end

  // Sticky: a refused write in the same cycle as a clear still sets it
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bad_dst_reg <= 1'b0;
    end else if (state_reg == DMX_ST_Q4 && op_dec == DMX_OP_MOVE && second_reg && dst_forbidden) begin
      bad_dst_reg <= 1'b1;
    end else if (bus_done && pwrite && paddr == `DMX_ADDR_STAT && pwdata[`DMX_STAT_BADDST]) begin
      bad_dst_reg <= 1'b0;
    end
  end

  // ==================================================
  // Outputs
  assign prdata      = prdata_reg;
  assign pready      = pready_reg;
  assign pslverr     = pslverr_reg;
  assign instr_ready = ready_reg;
  assign other_op    = other_reg;
  assign mem_addr    = maddr_reg;
  assign mem_rd      = mrd_reg;
  assign mem_wr      = mwr_reg;
  assign mem_wdata   = mwdata_reg;
  assign idx_mode    = idx_reg;
  assign acc_value   = acc_reg;
  assign bsr_value   = bsr_reg;
  assign flag_n      = n_reg;
  assign flag_z      = z_reg;
  assign phase       = state_reg;

endmodule

// File: verification/dmx_mem_model.sv
`timescale 1ns/1ps
// ====================
// Banked data memory, one cycle read latency
module dmx_mem_model (
  input  wire logic        sys_clk,
  input  wire logic [11:0] mem_addr,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [7:0]  mem_wdata,
  output logic      [7:0]  mem_rdata
);
  logic [7:0] mem [4096];

  initial mem_rdata = 8'h00;

  always @(posedge sys_clk) begin
    if (mem_wr)
      mem[mem_addr] <= mem_wdata;
    // Valid only in the cycle after a read; toggles so a sample one cycle late does not match
    if (mem_rd)
      mem_rdata <= mem[mem_addr];
    else
      mem_rdata <= ~mem_rdata;
  end
endmodule

// File: verification/dmx_core_assertions.sv
`timescale 1ns/1ps
`include "dmx_defs.svh"
// ====================
// Port checker
module dmx_checker (
  input wire logic                sys_clk,
  input wire logic                sys_rst,
  input wire logic                instr_valid,
  input wire logic [15:0]         instr_word,
  input wire logic                instr_ready,
  input wire logic                mem_rd,
  input wire logic                mem_wr,
  input wire logic [7:0]          acc_value,
  input wire logic [7:0]          bsr_value,
  input wire logic                flag_n,
  input wire logic                flag_z,
  input wire dmx_pkg::dmx_state_t phase
);
  import dmx_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic take;
  assign take = instr_valid && instr_ready && phase == DMX_ST_IDLE;
  // Second copy word taken; accumulator and refused targets leave memory alone
  logic take2;
  logic dst_special;
  assign take2 = phase == DMX_ST_WAIT2 && instr_valid && instr_ready && instr_word[15:12] == 4'hf;
  assign dst_special = instr_word[11:0] == `DMX_ACC_ADDR || instr_word[11:0] == `DMX_PCL_ADDR ||
                       instr_word[11:0] == `DMX_RETURN_STACK_LOW_ADDR || instr_word[11:0] == `DMX_RETURN_STACK_HIGH_ADDR ||
                       instr_word[11:0] == `DMX_RETURN_STACK_UPPER_ADDR;

  sequence s_quarters;
    phase == DMX_ST_Q2 ##1 phase == DMX_ST_Q3 ##1 phase == DMX_ST_Q4;
  endsequence
  sequence s_quiet_write;
    (!mem_rd && !mem_wr) [*3] ##1 (mem_wr && phase == DMX_ST_Q4);
  endsequence
  sequence s_silent;
    (!mem_rd && !mem_wr) [*4];
  endsequence

  property p_rd_phases; mem_rd |-> s_quarters; endproperty
  property p_wr_q4; mem_wr |-> phase == DMX_ST_Q4; endproperty
  property p_bsr_hi; bsr_value[7:4] == 4'h0; endproperty
  property p_acc_q4; $changed(acc_value) |-> $past(phase) == DMX_ST_Q4; endproperty
  property p_flags_q4; $changed({flag_n, flag_z}) |-> $past(phase) == DMX_ST_Q4; endproperty
  property p_load_acc;
    take && instr_word[15:8] == 8'h0e |-> ##5 acc_value == $past(instr_word[7:0], 5);
  endproperty
  property p_load_bsr;
    take && instr_word[15:8] == 8'h01 |-> ##5 bsr_value == {4'h0, $past(instr_word[3:0], 5)};
  endproperty
  property p_move_second;
    take2 && !dst_special |=> s_quiet_write;
  endproperty
  property p_move_to_acc;
    take2 && instr_word[11:0] == `DMX_ACC_ADDR |=> s_silent;
  endproperty

  a_rd_phases: assert property (p_rd_phases) else $error("read not in Q2 order");
  a_wr_q4: assert property (p_wr_q4) else $error("write outside Q4");
  a_bsr_hi: assert property (p_bsr_hi) else $error("bank upper nibble set");
  a_acc_q4: assert property (p_acc_q4) else $error("accumulator changed outside Q4");
  a_flags_q4: assert property (p_flags_q4) else $error("flags changed outside Q4");
  a_load_acc: assert property (p_load_acc) else $error("literal not in accumulator");
  a_load_bsr: assert property (p_load_bsr) else $error("literal not in bank select");
  a_move_second: assert property (p_move_second) else $error("second copy cycle wrong");
  a_move_to_acc: assert property (p_move_to_acc) else $error("memory touched on copy into accumulator");
endmodule

bind dmx_core dmx_checker chk_u (.sys_clk, .sys_rst, .instr_valid, .instr_word, .instr_ready, .mem_rd,
  .mem_wr, .acc_value, .bsr_value, .flag_n, .flag_z, .phase);

// File: verification/test_data_move_instruction_exec.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; \
  $display("BAD t=%0t got %0h exp %0h", $time, a, b); end end
module test_data_move_instruction_exec;
  import dmx_pkg::*;
  logic        sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, ext_set_en;
  logic        instr_valid, instr_ready, other_op, mem_rd, mem_wr, idx_mode, flag_n, flag_z, wr_idx;
  logic [11:0] paddr, mem_addr;
  logic [31:0] pwdata, prdata, rdat;
  logic [15:0] instr_word;
  logic [7:0]  mem_rdata, mem_wdata, acc_value, bsr_value;
  dmx_state_t  phase;
  int          num_errors, n_compared, n_other, cyc;

  dmx_core dut_u (.sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ext_set_en, .instr_valid, .instr_word, .instr_ready, .other_op, .mem_addr, .mem_rd, .mem_rdata, .mem_wr,
    .mem_wdata, .idx_mode, .acc_value, .bsr_value, .flag_n, .flag_z, .phase);
  dmx_mem_model mem_u (.sys_clk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata);

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (other_op === 1'b1) n_other++;
    if (mem_wr === 1'b1) wr_idx <= idx_mode;
    // Generous ceiling: the sequence needs well under a thousand cycles
    if (cyc == 5000) begin
      num_errors++;
      finish_test();
    end
  end

  // ====================
  // Access tasks
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin @(posedge sys_clk); end while (pready !== 1'b1);
    rdat = prdata;
    `CHK(pslverr, (a > 12'h008))
    psel <= 1'b0; penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task send(input logic [15:0] w);
    instr_valid <= 1'b1; instr_word <= w;
    do begin @(posedge sys_clk); end while (instr_ready !== 1'b1);
    instr_valid <= 1'b0;
    @(posedge sys_clk);
  endtask

  task run(input logic [15:0] w);
    send(w);
    while (!(phase === DMX_ST_IDLE && instr_ready === 1'b1)) begin @(posedge sys_clk); end
  endtask

  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ====================
  // Sequence
  initial begin
    sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
    ext_set_en = 1'b0; instr_valid = 1'b0; instr_word = 16'h0000; wr_idx = 1'b0;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    mem_u.mem[12'h520] = 8'h80; mem_u.mem[12'h521] = 8'h00; mem_u.mem[12'h123] = 8'h3c; mem_u.mem[12'h300] = 8'h11;
    run(16'h01f5); `CHK(bsr_value, 8'h05)
    run(16'h5320); `CHK({acc_value, flag_n, flag_z}, 10'h002)
    `CHK(mem_u.mem[12'h520], 8'h80)
    run(16'h5120); `CHK(acc_value, 8'h80)
    run(16'h5121); `CHK({acc_value, flag_n, flag_z}, 10'h001)
    run(16'h0e9a); `CHK({acc_value, flag_n, flag_z}, 10'h269)
    run(16'h6f34); `CHK(mem_u.mem[12'h534], 8'h9a)
    run(16'h6eff); `CHK(mem_u.mem[12'hfff], 8'h9a)
    run(16'h6e10); `CHK(mem_u.mem[12'h010], 8'h9a)
    $display("byte ops done");
    send(16'hc123); run(16'hf456); `CHK({mem_u.mem[12'h456], flag_n, flag_z}, 10'h0f1)
    send(16'hc300); run(16'hffe8); `CHK(acc_value, 8'h11)
    send(16'hcfe8); run(16'hf310); `CHK(mem_u.mem[12'h310], 8'h11)
    // An abandoned copy and a lone second word both raise other_op
    send(16'hc123); run(16'h0e77); `CHK({n_other, acc_value}, {32'd1, 8'h11})
    run(16'hffff); `CHK(n_other, 2)
    $display("copy ops done");
    ext_set_en <= 1'b1;
    repeat (3) @(posedge sys_clk);
    run(16'h6e5f); `CHK(wr_idx, 1'b1)
    run(16'h6e60); `CHK({wr_idx, mem_u.mem[12'hf60]}, 9'h011)
    ext_set_en <= 1'b0;
    $display("indexed mode done");
    apb(1'b0, 12'h004, 32'h0); `CHK(rdat[11:0], 12'h511)
    // Thirteen finished instructions; the abandoned copy and the foreign word do not count
    apb(1'b0, 12'h008, 32'h0); `CHK(rdat, 32'h0000_000d)
    apb(1'b0, 12'h00c, 32'h0); `CHK(rdat, 32'h0)
    apb(1'b1, 12'h000, 32'h0);
    instr_valid <= 1'b1; instr_word <= 16'h0e55;
    repeat (6) @(posedge sys_clk);
    `CHK({instr_ready, acc_value}, 9'h011)
    instr_valid <= 1'b0;
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b0, 12'h000, 32'h0); `CHK(rdat, 32'h0000_0001)
    $display("register access done");
    finish_test();
  end
endmodule
